// ---- src/adcsp_defines.svh ----
// constants, offsets and reset values of the serial register port
// Function
// RQ1: clock idles high; launch on falling edge, capture on rising edge.
// RQ2: port works with chip select tied low or driven by the host.
// RQ3: eight-bit command register is write only, never read back.
// RQ4: after reset the first byte is a command; host starts with it.
// RQ5: command byte picks direction; its six low bits address the register.
// RQ6: after the data phase the port waits for a new command byte.
// RQ7: data phase is 8, 16 or 24 bits, set only by the address.
// RQ8: read-only identification register holds a fixed part code.
// RQ9: 64 consecutive clocks with data input high reset every register.
// RQ10: chip select high aborts the transfer and awaits a command.
// RQ11: host resets the device after power-up and after losing sync.
// RQ12: reset enables channel 0 only, inputs zero and one, setup 0.
// RQ13: reset disables input and reference buffers; primary reference chosen.
// RQ14: reset selects sinc5 plus sinc1 filter at the highest rate.
// RQ15: reset selects continuous conversion and the internal oscillator.
// RQ16: reset disables interface checksum and status appending.
// RQ17: eight channels and eight setups, any pair, any setup.
// RQ18: each setup holds buffers, gain, offset, filter, rate, reference.
// RQ19: command bit 7 is write enable, bit 6 is direction.
// RQ20: all words shift most significant bit first.
`ifndef ADCSP_DEFINES_SVH
`define ADCSP_DEFINES_SVH

`define ADCSP_CMD_WEN_BIT 7
`define ADCSP_CMD_RW_BIT 6
`define ADCSP_CMD_BITS 5'd8
`define ADCSP_ADDR_W 6
`define ADCSP_A_COMMAND 6'h00
`define ADCSP_A_ADCMODE 6'h01
`define ADCSP_A_IFMODE 6'h02
`define ADCSP_A_IDENT 6'h07
`define ADCSP_G_MISC 3'h0
`define ADCSP_G_CHAN 3'h2
`define ADCSP_G_SETUP 3'h4
`define ADCSP_G_FILT 3'h5
`define ADCSP_G_OFFSET 3'h6
`define ADCSP_G_GAIN 3'h7
`define ADCSP_CH_EN_BIT 15
`define ADCSP_LEN_8 5'd8
`define ADCSP_LEN_16 5'd16
`define ADCSP_LEN_24 5'd24
`define ADCSP_ONES_LAST 6'd63
`define ADCSP_RST_CHAN_FIRST 16'h8001
`define ADCSP_RST_CHN 16'h0001
`define ADCSP_RST_SETUP 16'h1000
`define ADCSP_RST_FILT 16'h0500
`define ADCSP_RST_OFFSET 24'h80_0000
`define ADCSP_RST_GAIN 24'h50_0000
`define ADCSP_RST_ADCMODE 16'h0000
`define ADCSP_RST_IFMODE 16'h0000
`define ADCSP_RST_CHEN 8'h01
`define ADCSP_ID_DEFAULT 16'h1230

`endif

// ---- src/adcsp_pkg.sv ----
// types shared by the serial register port modules
package adcsp_pkg;
    typedef enum logic [1:0] {CMD_ST, WR_ST, RD_ST} adcsp_state_type;
    typedef logic [7:0] adcsp_chen_type;
    typedef logic [15:0] adcsp_w16_type;
    typedef logic [39:0] adcsp_cfg_type;
endpackage

// ---- src/adcsp_sync.sv ----
// reference clock side of the configuration word handshake
`timescale 1ns/100ps
`include "adcsp_defines.svh"
module adcsp_sync (
    input wire logic ref_clk,
    input wire logic rst_b,
    adcsp_xfer_if.dst xfer,
    output adcsp_pkg::adcsp_cfg_type cfg
);
    import adcsp_pkg::*;

    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    logic ack_q;
    adcsp_cfg_type cfg_q;

    // ********************************
    // toggle synchroniser and capture
    // ********************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            req_s1_q <= xfer.req_tgl;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            ack_q <= req_s3_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= {`ADCSP_RST_CHEN, `ADCSP_RST_ADCMODE, `ADCSP_RST_IFMODE};
        end else if (req_s2_q != req_s3_q) begin
            cfg_q <= xfer.word;
        end
    end

    assign xfer.ack_tgl = ack_q;
    assign cfg = cfg_q;
endmodule

// ---- src/adcsp_top.sv ----
// serial register port of the converter, link logic on the serial clock
`timescale 1ns/100ps
`include "adcsp_defines.svh"
module adcsp_top #(
    parameter logic [15:0] ID_CODE = `ADCSP_ID_DEFAULT // arbitrary value
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic din,
    output logic sdo,
    output logic sdo_oe,
    output adcsp_pkg::adcsp_chen_type chan_en,
    output adcsp_pkg::adcsp_w16_type adc_mode,
    output adcsp_pkg::adcsp_w16_type if_mode
);
    import adcsp_pkg::*;

    adcsp_state_type state_q;
    logic frame_rst_b;
    logic [4:0] cnt_q;
    logic [4:0] len_q;
    logic [5:0] addr_q;
    logic [22:0] sh_q;
    logic [23:0] rd_sh_q;
    logic [5:0] ones_q;
    logic soft_rst;
    logic [7:0] cmd_byte;
    logic cmd_done;
    logic last_bit;
    logic wr_fire;
    logic [23:0] wr_word;
    logic [23:0] rd_val;
    logic [23:0] rd_algn;
    logic [4:0] cmd_len;
    logic [15:0] ch_q [8];
    logic [15:0] setup_q [8];
    logic [15:0] filt_q [8];
    logic [23:0] off_q [8];
    logic [23:0] gain_q [8];
    logic [15:0] adcmode_q;
    logic [15:0] ifmode_q;
    logic [7:0] chen_live;
    logic sdo_q;
    logic sdo_oe_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic req_q;
    adcsp_cfg_type word_q;
    adcsp_cfg_type cfg;

    // ********************************
    // frame decode
    // ********************************
    assign frame_rst_b = rst_b & ~cs_b; // RQ10 RQ2
    assign cmd_byte = {sh_q[6:0], din}; // RQ20
    assign cmd_done = (state_q == CMD_ST) && (cnt_q == `ADCSP_CMD_BITS - 5'd1);
    assign last_bit = (cnt_q == len_q - 5'd1);
    assign wr_fire = (state_q == WR_ST) && last_bit && !soft_rst;
    assign wr_word = {sh_q, din}; // RQ20
    assign soft_rst = din && (ones_q == `ADCSP_ONES_LAST); // RQ9

    // data length from the address alone
    always_comb begin
        cmd_len = `ADCSP_LEN_8; // RQ7
        case (cmd_byte[5:3])
            `ADCSP_G_MISC: begin
                if (cmd_byte[5:0] == `ADCSP_A_ADCMODE ||
                    cmd_byte[5:0] == `ADCSP_A_IFMODE ||
                    cmd_byte[5:0] == `ADCSP_A_IDENT) begin
                    cmd_len = `ADCSP_LEN_16;
                end
            end
            `ADCSP_G_CHAN, `ADCSP_G_SETUP, `ADCSP_G_FILT: begin
                cmd_len = `ADCSP_LEN_16;
            end
            `ADCSP_G_OFFSET, `ADCSP_G_GAIN: begin
                cmd_len = `ADCSP_LEN_24;
            end
            default: begin
                cmd_len = `ADCSP_LEN_8;
            end
        endcase
    end

    // read value of the addressed register
    always_comb begin
        rd_val = 24'h00_0000; // RQ3
        case (cmd_byte[5:3])
            `ADCSP_G_MISC: begin
                case (cmd_byte[5:0])
                    `ADCSP_A_ADCMODE: rd_val = {8'h00, adcmode_q};
                    `ADCSP_A_IFMODE: rd_val = {8'h00, ifmode_q};
                    `ADCSP_A_IDENT: rd_val = {8'h00, ID_CODE}; // RQ8
                    default: rd_val = 24'h00_0000;
                endcase
            end
            `ADCSP_G_CHAN: rd_val = {8'h00, ch_q[cmd_byte[2:0]]};
            `ADCSP_G_SETUP: rd_val = {8'h00, setup_q[cmd_byte[2:0]]};
            `ADCSP_G_FILT: rd_val = {8'h00, filt_q[cmd_byte[2:0]]};
            `ADCSP_G_OFFSET: rd_val = off_q[cmd_byte[2:0]];
            `ADCSP_G_GAIN: rd_val = gain_q[cmd_byte[2:0]];
            default: rd_val = 24'h00_0000;
        endcase
        rd_algn = rd_val;
        if (cmd_len == `ADCSP_LEN_8) begin
            rd_algn = {rd_val[7:0], 16'h0000}; // RQ20
        end else if (cmd_len == `ADCSP_LEN_16) begin
            rd_algn = {rd_val[15:0], 8'h00};
        end
    end

    // ********************************
    // frame sequencer, rising edge
    // ********************************
    always_ff @(posedge sclk or negedge frame_rst_b) begin // RQ1
        if (!frame_rst_b) begin
            state_q <= CMD_ST; // RQ4 RQ10
            cnt_q <= 5'd0;
            len_q <= `ADCSP_LEN_8;
            addr_q <= 6'h00;
            sh_q <= 23'h00_0000;
            rd_sh_q <= 24'h00_0000;
        end else if (soft_rst) begin
            state_q <= CMD_ST; // RQ9
            cnt_q <= 5'd0;
            sh_q <= 23'h00_0000;
        end else begin
            sh_q <= {sh_q[21:0], din};
            case (state_q)
                CMD_ST: begin
                    if (cmd_done) begin
                        cnt_q <= 5'd0;
                        if (!cmd_byte[`ADCSP_CMD_WEN_BIT]) begin // RQ19
                            addr_q <= cmd_byte[5:0]; // RQ5
                            len_q <= cmd_len; // RQ7
                            rd_sh_q <= rd_algn;
                            if (cmd_byte[`ADCSP_CMD_RW_BIT]) begin // RQ5
                                state_q <= RD_ST;
                            end else begin
                                state_q <= WR_ST;
                            end
                        end
                    end else begin
                        cnt_q <= cnt_q + 5'd1;
                    end
                end
                WR_ST, RD_ST: begin
                    if (last_bit) begin
                        state_q <= CMD_ST; // RQ6
                        cnt_q <= 5'd0;
                    end else begin
                        cnt_q <= cnt_q + 5'd1;
                    end
                end
                default: begin
                    state_q <= CMD_ST;
                    cnt_q <= 5'd0;
                end
            endcase
        end
    end

    // consecutive ones counter for the interface reset
    always_ff @(posedge sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            ones_q <= 6'd0;
        end else if (!din || soft_rst) begin
            ones_q <= 6'd0; // RQ9
        end else begin
            ones_q <= ones_q + 6'd1;
        end
    end

    // ********************************
    // output shifter, falling edge
    // ********************************
    always_ff @(negedge sclk or negedge frame_rst_b) begin // RQ1
        if (!frame_rst_b) begin
            sdo_q <= 1'b1;
            sdo_oe_q <= 1'b0; // RQ10
        end else begin
            sdo_oe_q <= (state_q == RD_ST);
            if (state_q == RD_ST) begin
                sdo_q <= rd_sh_q[5'd23 - cnt_q]; // RQ20
            end else begin
                sdo_q <= 1'b1;
            end
        end
    end

    assign sdo = sdo_q;
    assign sdo_oe = sdo_oe_q;

    // ********************************
    // per-entry channels and setups
    // ********************************
    for (genvar gi = 0; gi < 8; gi++) begin : g_entry
        localparam logic [15:0] CH_RST =
            (gi == 0) ? `ADCSP_RST_CHAN_FIRST : `ADCSP_RST_CHN;
        always_ff @(posedge sclk or negedge rst_b) begin
            if (!rst_b) begin
                ch_q[gi] <= CH_RST; // RQ12
                setup_q[gi] <= `ADCSP_RST_SETUP; // RQ13
                filt_q[gi] <= `ADCSP_RST_FILT; // RQ14
                off_q[gi] <= `ADCSP_RST_OFFSET;
                gain_q[gi] <= `ADCSP_RST_GAIN;
            end else if (soft_rst) begin
                ch_q[gi] <= CH_RST; // RQ9 RQ12
                setup_q[gi] <= `ADCSP_RST_SETUP; // RQ13
                filt_q[gi] <= `ADCSP_RST_FILT; // RQ14
                off_q[gi] <= `ADCSP_RST_OFFSET;
                gain_q[gi] <= `ADCSP_RST_GAIN;
            end else if (wr_fire && addr_q[2:0] == 3'(gi)) begin // RQ17
                case (addr_q[5:3])
                    `ADCSP_G_CHAN: ch_q[gi] <= wr_word[15:0];
                    `ADCSP_G_SETUP: setup_q[gi] <= wr_word[15:0]; // RQ18
                    `ADCSP_G_FILT: filt_q[gi] <= wr_word[15:0]; // RQ18
                    `ADCSP_G_OFFSET: off_q[gi] <= wr_word; // RQ18
                    `ADCSP_G_GAIN: gain_q[gi] <= wr_word; // RQ18
                    default: ch_q[gi] <= ch_q[gi];
                endcase
            end
        end
        assign chen_live[gi] = ch_q[gi][`ADCSP_CH_EN_BIT];
    end

    // mode registers
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            adcmode_q <= `ADCSP_RST_ADCMODE; // RQ15
            ifmode_q <= `ADCSP_RST_IFMODE; // RQ16
        end else if (soft_rst) begin
            adcmode_q <= `ADCSP_RST_ADCMODE; // RQ9 RQ15
            ifmode_q <= `ADCSP_RST_IFMODE; // RQ16
        end else if (wr_fire && addr_q == `ADCSP_A_ADCMODE) begin
            adcmode_q <= wr_word[15:0];
        end else if (wr_fire && addr_q == `ADCSP_A_IFMODE) begin
            ifmode_q <= wr_word[15:0];
        end
    end

    // ********************************
    // configuration crossing
    // ********************************
    adcsp_xfer_if xfer ();

    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            req_q <= 1'b0;
            word_q <= {`ADCSP_RST_CHEN, `ADCSP_RST_ADCMODE, `ADCSP_RST_IFMODE};
        end else begin
            ack_s1_q <= xfer.ack_tgl;
            ack_s2_q <= ack_s1_q;
            if (ack_s2_q == req_q &&
                word_q != {chen_live, adcmode_q, ifmode_q}) begin
                word_q <= {chen_live, adcmode_q, ifmode_q};
                req_q <= ~req_q;
            end
        end
    end

    assign xfer.word = word_q;
    assign xfer.req_tgl = req_q;

    adcsp_sync u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .xfer(xfer),
        .cfg(cfg)
    );

    assign chan_en = cfg[39:32];
    assign adc_mode = cfg[31:16];
    assign if_mode = cfg[15:0];

    // ********************************
    // assertions
    // ********************************
    property p_soft_rst_cmd;
        @(posedge sclk) disable iff (!frame_rst_b)
        soft_rst |=> (state_q == CMD_ST) && (cnt_q == 5'd0);
    endproperty
    a_soft_rst_cmd: assert property (p_soft_rst_cmd) // RQ9
        else $error("interface reset did not return to command");

    property p_wen_ignored;
        @(posedge sclk) disable iff (!frame_rst_b)
        cmd_done && cmd_byte[7] && !soft_rst |=> state_q == CMD_ST;
    endproperty
    a_wen_ignored: assert property (p_wen_ignored) // RQ19
        else $error("command with write enable high was accepted");

    property p_dir;
        @(posedge sclk) disable iff (!frame_rst_b)
        cmd_done && !cmd_byte[7] && !soft_rst |=>
        state_q == ($past(cmd_byte[6]) ? RD_ST : WR_ST) &&
        addr_q == $past(cmd_byte[5:0]);
    endproperty
    a_dir: assert property (p_dir) // RQ5
        else $error("command direction or address lost");

    property p_len;
        @(posedge sclk) disable iff (!frame_rst_b)
        state_q == CMD_ST ##1 state_q != CMD_ST |->
        len_q == (addr_q[5:4] == 2'b11 ? 5'd24 :
                  (addr_q[5:4] == 2'b10 || addr_q[5:3] == 3'h2 ||
                   addr_q == 6'h01 || addr_q == 6'h02 ||
                   addr_q == 6'h07) ? 5'd16 : 5'd8);
    endproperty
    a_len: assert property (p_len) // RQ7
        else $error("data length does not match address");

    property p_return;
        @(posedge sclk) disable iff (!frame_rst_b)
        state_q == WR_ST && cnt_q == 5'd0 && len_q == 5'd16 |->
        ##[15:16] state_q == CMD_ST;
    endproperty
    a_return: assert property (p_return) // RQ6
        else $error("port did not return to command after data");

    property p_id;
        @(posedge sclk) disable iff (!frame_rst_b)
        state_q == RD_ST && addr_q == 6'h07 |-> rd_sh_q[23:8] == ID_CODE;
    endproperty
    a_id: assert property (p_id) // RQ8
        else $error("identification read wrong");

    property p_cmd_wo;
        @(posedge sclk) disable iff (!frame_rst_b)
        state_q == RD_ST && addr_q == 6'h00 |-> rd_sh_q == 24'h00_0000;
    endproperty
    a_cmd_wo: assert property (p_cmd_wo) // RQ3
        else $error("command register read back");

    property p_defaults;
        @(posedge sclk) disable iff (!rst_b)
        soft_rst |=> ch_q[0] == 16'h8001 && ch_q[1] == 16'h0001 &&
        setup_q[0] == 16'h1000 && filt_q[0] == 16'h0500 &&
        adcmode_q == 16'h0000 && ifmode_q == 16'h0000;
    endproperty
    a_defaults: assert property (p_defaults) // RQ12
        else $error("register defaults not restored");

    property p_oe;
        @(posedge sclk) disable iff (!frame_rst_b)
        sdo_oe_q |-> state_q == RD_ST;
    endproperty
    a_oe: assert property (p_oe) // RQ1
        else $error("output driven outside a read");
endmodule

// ---- src/adcsp_xfer_if.sv ----
// word crossing from the serial clock to the reference clock
`timescale 1ns/100ps
interface adcsp_xfer_if;
    adcsp_pkg::adcsp_cfg_type word;
    logic req_tgl;
    logic ack_tgl;
    modport src (output word, output req_tgl, input ack_tgl);
    modport dst (input word, input req_tgl, output ack_tgl);
endinterface

// ---- tb/adcsp_host_model.sv ----
// host controller model that drives the serial register link
`timescale 1ns/100ps
module adcsp_host_model (
    output logic sclk,
    output logic cs_b,
    output logic din,
    input wire logic sdo,
    input wire logic sdo_oe
);
    int oe_cnt;

    initial begin
        sclk = 1'b1;
        cs_b = 1'b1;
        din = 1'b0;
        oe_cnt = 0;
    end

    // chip select low opens a frame, clock still idle high
    task automatic open_frame();
        cs_b = 1'b0;
        #3;
    endtask

    // released data line toggles so no stale level is seen
    task automatic close_frame();
        #3;
        cs_b = 1'b1;
        din = ~din;
        #3;
    endtask

    // msb first, launch on falling edge, capture on rising edge
    task automatic shift(input int n, input logic [23:0] w,
                         output logic [23:0] r);
        int i;
        r = '0;
        oe_cnt = 0;
        for (i = n - 1; i >= 0; i--) begin
            sclk = 1'b0;
            din = w[i];
            #3;
            sclk = 1'b1;
            r = {r[22:0], sdo};
            if (sdo_oe === 1'b1) begin
                oe_cnt++;
            end
            #3;
        end
    endtask

    // clocks with chip select high let the settings cross
    task automatic idle(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            sclk = 1'b0;
            din = ~din;
            #3;
            sclk = 1'b1;
            #3;
        end
    endtask

    // run of ones on the data line resynchronises the port
    task automatic ones(input int n);
        int i;
        logic [23:0] r;
        for (i = 0; i < n; i++) begin
            shift(1, 24'h00_0001, r);
        end
    endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the serial register port
`timescale 1ns/100ps
module tb_top;
    import adcsp_pkg::*;
    localparam logic [15:0] ID_VAL = 16'h3c5a; // arbitrary value
    logic ref_clk, rst_b, sclk, cs_b, din, sdo, sdo_oe;
    adcsp_chen_type chan_en;
    adcsp_w16_type adc_mode, if_mode;
    int num_errors, checks_done, cycles, i;
    logic [23:0] rd_v;
    logic [5:0] def_a [9] = '{6'h10, 6'h17, 6'h20, 6'h27, 6'h28,
                              6'h30, 6'h38, 6'h01, 6'h02};
    int def_n [9] = '{16, 16, 16, 16, 16, 24, 24, 16, 16};
    logic [23:0] def_v [9] = '{24'h00_8001, 24'h00_0001, 24'h00_1000,
                               24'h00_1000, 24'h00_0500, 24'h80_0000,
                               24'h50_0000, 24'h00_0000, 24'h00_0000};
    logic [5:0] wr_a [7] = '{6'h17, 6'h27, 6'h2f, 6'h37, 6'h3f, 6'h01,
                             6'h02};
    int wr_n [7] = '{16, 16, 16, 24, 24, 16, 16};
    logic [23:0] wr_v [7] = '{24'h00_f0a3, 24'h00_1f20, 24'h00_0e45,
                              24'h12_3456, 24'h65_4321, 24'h00_2a5c,
                              24'h00_0c33};

    adcsp_top #(.ID_CODE(ID_VAL)) u_adcsp_top (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .sclk(sclk),
        .cs_b(cs_b),
        .din(din),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .chan_en(chan_en),
        .adc_mode(adc_mode),
        .if_mode(if_mode)
    );

    adcsp_host_model u_adcsp_host_model (
        .sclk(sclk),
        .cs_b(cs_b),
        .din(din),
        .sdo(sdo),
        .sdo_oe(sdo_oe)
    );

    // ****************************************
    // clock, timeout and helpers
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        cycles = 0;
    end

    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmd_rd(input logic [5:0] a, input int n,
                          output logic [23:0] v);
        logic [23:0] r;
        u_adcsp_host_model.shift(8, {18'h0, 2'b01, a}, r);
        check(24'(u_adcsp_host_model.oe_cnt), 24'h00_0000);
        u_adcsp_host_model.shift(n, 24'h00_0000, v);
        check(24'(u_adcsp_host_model.oe_cnt), 24'(n));
    endtask

    task automatic cmd_wr(input logic [5:0] a, input int n,
                          input logic [23:0] v);
        logic [23:0] r;
        u_adcsp_host_model.shift(8, {18'h0, 2'b00, a}, r);
        u_adcsp_host_model.shift(n, v, r);
    endtask

    task automatic wait_chen(input logic [7:0] exp);
        int k;
        u_adcsp_host_model.idle(8);
        for (k = 0; k < 40 && chan_en !== exp; k++) begin
            @(negedge ref_clk);
        end
        check({16'h0, chan_en}, {16'h0, exp});
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        num_errors = 0;
        checks_done = 0;
        rst_b = 1'b0;
        u_adcsp_host_model.idle(2);
        repeat (3) @(negedge ref_clk);
        rst_b = 1'b1;
        check({16'h0, chan_en}, 24'h00_0001);
        check({8'h0, adc_mode}, 24'h00_0000);
        check({8'h0, if_mode}, 24'h00_0000);
        // host reset after power-up
        u_adcsp_host_model.open_frame();
        u_adcsp_host_model.ones(64);
        u_adcsp_host_model.close_frame();
        // defaults, all in one frame with chip select held low
        u_adcsp_host_model.open_frame();
        for (i = 0; i < 9; i++) begin
            cmd_rd(def_a[i], def_n[i], rd_v);
            check(rd_v, def_v[i]);
        end
        // per-channel, per-setup and mode writes, back to back
        for (i = 0; i < 7; i++) begin
            cmd_wr(wr_a[i], wr_n[i], wr_v[i]);
        end
        for (i = 0; i < 7; i++) begin
            cmd_rd(wr_a[i], wr_n[i], rd_v);
            check(rd_v, wr_v[i]);
        end
        u_adcsp_host_model.close_frame();
        wait_chen(8'h81);
        check({8'h0, adc_mode}, 24'h00_2a5c);
        check({8'h0, if_mode}, 24'h00_0c33);
        // identification, command and unmapped reads
        u_adcsp_host_model.open_frame();
        cmd_wr(6'h07, 16, 24'h00_0000);
        cmd_rd(6'h07, 16, rd_v);
        check(rd_v, {8'h0, ID_VAL});
        cmd_rd(6'h00, 8, rd_v);
        check(rd_v, 24'h00_0000);
        cmd_rd(6'h08, 8, rd_v);
        check(rd_v, 24'h00_0000);
        u_adcsp_host_model.shift(8, 24'h00_00c7, rd_v);
        cmd_rd(6'h07, 16, rd_v);
        check(rd_v, {8'h0, ID_VAL});
        u_adcsp_host_model.close_frame();
        // chip select high in mid data phase
        u_adcsp_host_model.open_frame();
        u_adcsp_host_model.shift(8, 24'h00_0010, rd_v);
        u_adcsp_host_model.shift(8, 24'h00_00ff, rd_v);
        u_adcsp_host_model.close_frame();
        u_adcsp_host_model.open_frame();
        cmd_rd(6'h10, 16, rd_v);
        check(rd_v, 24'h00_8001);
        u_adcsp_host_model.close_frame();
        // one short of the reset run, then one past the run
        u_adcsp_host_model.open_frame();
        u_adcsp_host_model.ones(63);
        u_adcsp_host_model.close_frame();
        u_adcsp_host_model.open_frame();
        cmd_rd(6'h17, 16, rd_v);
        check(rd_v, 24'h00_f0a3);
        u_adcsp_host_model.close_frame();
        u_adcsp_host_model.open_frame();
        u_adcsp_host_model.ones(65);
        u_adcsp_host_model.close_frame();
        wait_chen(8'h01);
        check({8'h0, adc_mode}, 24'h00_0000);
        check({8'h0, if_mode}, 24'h00_0000);
        u_adcsp_host_model.open_frame();
        cmd_rd(6'h17, 16, rd_v);
        check(rd_v, 24'h00_0001);
        cmd_rd(6'h3f, 24, rd_v);
        check(rd_v, 24'h50_0000);
        u_adcsp_host_model.close_frame();
        report_and_stop();
    end
endmodule
